// ---- shared/sbm_pkg.sv ----
// Purpose: shared constants and types for the skip/branch/move execution slice
// Assumes: 12-bit instruction word, 8-bit data path, 32 file registers
// Notes: opcode patterns are matched under the field widths given here
`default_nettype none
package sbm_pkg;
  // widths
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W = 11;
  localparam int JUMP_W = 9;
  localparam int LIT_W = 8;
  // field positions
  localparam int DEST_BIT = 5;
  localparam int OP6_LSB = 6;
  localparam int OP7_LSB = 5;
  localparam int OP4_LSB = 8;
  localparam int OP3_LSB = 9;
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 5;
  // opcode patterns
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;
  localparam logic [5:0] OP_OR_REG = 6'h04;
  localparam logic [5:0] OP_MOVE_F = 6'h08;
  localparam logic [6:0] OP_STORE_ACC = 7'h01;
  localparam logic [3:0] OP_OR_LIT = 4'hD;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [11:0] OP_IDLE = 12'h000;
  // values
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO_DATA = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FADDR_RST = 5'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic DEST_ACC = 1'b0;

  typedef enum logic [2:0] {
    ALU_DEC = 3'h0,
    ALU_INC = 3'h1,
    ALU_OR_F = 3'h2,
    ALU_OR_LIT = 3'h3,
    ALU_PASS_F = 3'h4,
    ALU_PASS_W = 3'h5
  } sbm_alu_op_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } sbm_state_t;
endpackage
`default_nettype wire

// ---- hdl/sbm_alu.sv ----
// Purpose: data path for the skip/branch/move slice
// Assumes: purely combinational, operands valid in the execute cycle
// Notes: zero is computed on the full eight-bit result
`default_nettype none
module sbm_alu (
  // operation
  input wire sbm_pkg::sbm_alu_op_t op_in,
  // operands
  input wire logic [sbm_pkg::DATA_W-1:0] acc_in,
  input wire logic [sbm_pkg::DATA_W-1:0] file_in,
  input wire logic [sbm_pkg::LIT_W-1:0] lit_in,
  // result
  output logic [sbm_pkg::DATA_W-1:0] result_out,
  output logic zero_out
);
  import sbm_pkg::*;

  always_comb begin
    unique case (op_in)
      ALU_DEC: result_out = file_in - ONE;
      ALU_INC: result_out = file_in + ONE;
      ALU_OR_F: result_out = acc_in | file_in;
      ALU_OR_LIT: result_out = acc_in | lit_in;
      ALU_PASS_F: result_out = file_in;
      ALU_PASS_W: result_out = acc_in;
      default: result_out = acc_in;
    endcase
  end

  // set when all eight bits are clear
  assign zero_out = (result_out == ZERO_DATA);
endmodule
`default_nettype wire

// ---- hdl/sbm_exec.sv ----
// Purpose: executes decrement/increment-skip, jump, OR and move instructions
// Assumes: one instruction offered per valid cycle; file read data is
//   combinational from file_raddr_out in the same cycle
// Notes: the accumulator lives here; the zero flag is handed out as a
//   write strobe plus value for the status register
// Function
// - decrement-skip subtracts one from file register 0..31 into the destination.
// - a zero decrement result discards the fetched next instruction as an idle cycle.
// - increment-skip adds one into the destination and neither skip alters a flag.
// - a zero increment result discards the fetched next instruction as an idle cycle.
// - the jump loads its 9-bit immediate into program counter bits 8..0.
// - the literal OR ORs an 8-bit immediate into the accumulator and updates zero.
// - the register OR ORs accumulator with the file register to the destination, zero too.
// - destination bit 0 selects the accumulator and 1 the addressed file register.
// - the store copies the accumulator into the file register without flag change.
// - the file move copies the file register to the destination-selected target.
// - the file move updates zero from the moved value even writing back to itself.
`default_nettype none
module sbm_exec (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // instruction stream
  input wire logic [sbm_pkg::INSTR_W-1:0] instr_in,
  input wire logic instr_valid_in,
  // file register and status access
  input wire logic [sbm_pkg::DATA_W-1:0] file_rdata_in,
  input wire logic [sbm_pkg::DATA_W-1:0] status_in,
  output logic [sbm_pkg::FADDR_W-1:0] file_raddr_out,
  output logic file_we_out,
  output logic [sbm_pkg::FADDR_W-1:0] file_waddr_out,
  output logic [sbm_pkg::DATA_W-1:0] file_wdata_out,
  // accumulator and zero flag
  output logic [sbm_pkg::DATA_W-1:0] acc_out,
  output logic zero_we_out,
  output logic zero_out,
  // program flow
  output logic pc_load_out,
  output logic [sbm_pkg::PC_W-1:0] pc_target_out,
  output logic discard_out,
  output logic unknown_op_out
);
  import sbm_pkg::*;

  sbm_state_t state, next_state;
  logic [DATA_W-1:0] acc, next_acc;
  logic file_we, next_file_we;
  logic [FADDR_W-1:0] file_waddr, next_file_waddr;
  logic [DATA_W-1:0] file_wdata, next_file_wdata;
  logic zero_we, next_zero_we;
  logic zero, next_zero;
  logic pc_load, next_pc_load;
  logic [PC_W-1:0] pc_target, next_pc_target;
  logic discard, next_discard;
  logic unknown_op, next_unknown_op;

  logic exec;
  logic dest_file;
  logic is_dec, is_inc, is_or_reg, is_move, is_store, is_or_lit, is_jump, is_idle;
  logic known;
  sbm_alu_op_t alu_op;
  logic [DATA_W-1:0] alu_result;
  logic alu_zero;

  // decode
  assign exec = instr_valid_in && (state == ST_EXEC);
  assign dest_file = (instr_in[DEST_BIT] != DEST_ACC);
  assign is_dec = (instr_in[INSTR_W-1:OP6_LSB] == OP_DEC_SKIP);
  assign is_inc = (instr_in[INSTR_W-1:OP6_LSB] == OP_INC_SKIP);
  assign is_or_reg = (instr_in[INSTR_W-1:OP6_LSB] == OP_OR_REG);
  assign is_move = (instr_in[INSTR_W-1:OP6_LSB] == OP_MOVE_F);
  assign is_store = (instr_in[INSTR_W-1:OP7_LSB] == OP_STORE_ACC);
  assign is_or_lit = (instr_in[INSTR_W-1:OP4_LSB] == OP_OR_LIT);
  assign is_jump = (instr_in[INSTR_W-1:OP3_LSB] == OP_JUMP);
  assign is_idle = (instr_in == OP_IDLE);
  assign known = is_dec || is_inc || is_or_reg || is_move || is_store ||
                 is_or_lit || is_jump || is_idle;
  assign file_raddr_out = instr_in[FADDR_W-1:0];

  always_comb begin
    if (is_dec) begin
      alu_op = ALU_DEC;
    end else if (is_inc) begin
      alu_op = ALU_INC;
    end else if (is_or_reg) begin
      alu_op = ALU_OR_F;
    end else if (is_or_lit) begin
      alu_op = ALU_OR_LIT;
    end else if (is_move) begin
      alu_op = ALU_PASS_F;
    end else begin
      alu_op = ALU_PASS_W;
    end
  end

  sbm_alu u_alu (
    .op_in(alu_op),
    .acc_in(acc),
    .file_in(file_rdata_in),
    .lit_in(instr_in[LIT_W-1:0]),
    .result_out(alu_result),
    .zero_out(alu_zero)
  );

  always_comb begin
    next_state = state;
    next_acc = acc;
    next_file_we = 1'b0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    next_zero_we = 1'b0;
    next_zero = zero;
    next_pc_load = 1'b0;
    next_pc_target = pc_target;
    next_discard = 1'b0;
    next_unknown_op = 1'b0;
    if (instr_valid_in) begin
      unique case (state)
        ST_EXEC: begin
          next_unknown_op = !known;
          if (is_dec || is_inc || is_or_reg || is_move) begin
            if (dest_file) begin
              next_file_we = 1'b1;
              next_file_waddr = instr_in[FADDR_W-1:0];
              next_file_wdata = alu_result;
            end else begin
              next_acc = alu_result;
            end
          end
          if (is_store) begin
            next_file_we = 1'b1;
            next_file_waddr = instr_in[FADDR_W-1:0];
            next_file_wdata = alu_result;
          end
          if (is_or_lit) begin
            next_acc = alu_result;
          end
          // skips and jump leave the flag alone
          if (is_or_reg || is_or_lit || is_move) begin
            next_zero_we = 1'b1;
            next_zero = alu_zero;
          end
          if ((is_dec || is_inc) && alu_zero) begin
            next_state = ST_FLUSH;
          end
          if (is_jump) begin
            next_pc_load = 1'b1;
            next_pc_target = {status_in[PAGE_HI], status_in[PAGE_LO],
                              instr_in[JUMP_W-1:0]};
            next_state = ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          // prefetched word is dropped: behaves as an idle instruction
          next_discard = 1'b1;
          next_state = ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_EXEC;
      acc <= ACC_RST;
      file_we <= 1'b0;
      file_waddr <= FADDR_RST;
      file_wdata <= ZERO_DATA;
      zero_we <= 1'b0;
      zero <= 1'b0;
      pc_load <= 1'b0;
      pc_target <= PC_RST;
      discard <= 1'b0;
      unknown_op <= 1'b0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      file_we <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
      zero_we <= next_zero_we;
      zero <= next_zero;
      pc_load <= next_pc_load;
      pc_target <= next_pc_target;
      discard <= next_discard;
      unknown_op <= next_unknown_op;
    end
  end

  assign acc_out = acc;
  assign file_we_out = file_we;
  assign file_waddr_out = file_waddr;
  assign file_wdata_out = file_wdata;
  assign zero_we_out = zero_we;
  assign zero_out = zero;
  assign pc_load_out = pc_load;
  assign pc_target_out = pc_target;
  assign discard_out = discard;
  assign unknown_op_out = unknown_op;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_DEC_RESULT: assert property (
    exec && is_dec |=> (file_we_out ? file_wdata_out : acc_out) ==
      DATA_W'($past(file_rdata_in) - ONE))
    else $error("decrement result wrong");

  AST_DEC_SKIP: assert property (
    exec && is_dec && file_rdata_in == ONE ##1 instr_valid_in
      |=> discard_out && !file_we_out && !pc_load_out && !zero_we_out)
    else $error("zero decrement did not discard next word");

  AST_INC_NO_FLAG: assert property (
    exec && (is_inc || is_dec) |=> !zero_we_out &&
      (!$past(is_inc) || (file_we_out ? file_wdata_out : acc_out) ==
        DATA_W'($past(file_rdata_in) + ONE)))
    else $error("increment result or flag wrong");

  AST_INC_SKIP: assert property (
    exec && is_inc && file_rdata_in == 8'hFF ##1 instr_valid_in
      |=> discard_out && !file_we_out && !zero_we_out)
    else $error("zero increment did not discard next word");

  AST_JUMP_LOW: assert property (
    exec && is_jump |=> pc_load_out &&
      pc_target_out[JUMP_W-1:0] == $past(instr_in[JUMP_W-1:0]))
    else $error("jump low bits wrong");

  AST_JUMP_PAGE: assert property (
    exec && is_jump |=> pc_target_out[PC_W-1:JUMP_W] ==
      $past(status_in[PAGE_HI:PAGE_LO]) && !zero_we_out && state == ST_FLUSH)
    else $error("jump page bits or timing wrong");

  AST_OR_LIT: assert property (
    exec && is_or_lit |=> zero_we_out &&
      acc_out == ($past(acc_out) | $past(instr_in[LIT_W-1:0])))
    else $error("literal OR wrong");

  AST_OR_REG: assert property (
    exec && is_or_reg |=> zero_we_out &&
      (file_we_out ? file_wdata_out : acc_out) ==
      ($past(acc_out) | $past(file_rdata_in)))
    else $error("register OR wrong");

  AST_DEST_SEL: assert property (
    exec && (is_dec || is_inc || is_or_reg || is_move)
      |=> file_we_out == $past(dest_file) &&
      (file_we_out || acc_out == $past(alu_result)))
    else $error("destination select wrong");

  AST_STORE: assert property (
    exec && is_store |=> file_we_out && file_wdata_out == $past(acc_out) &&
      file_waddr_out == $past(instr_in[FADDR_W-1:0]) && !zero_we_out)
    else $error("store wrong");

  AST_MOVE: assert property (
    exec && is_move |=> (file_we_out ? file_wdata_out : acc_out) ==
      $past(file_rdata_in))
    else $error("file move wrong");

  AST_MOVE_ZERO: assert property (
    exec && is_move && dest_file |=> zero_we_out &&
      zero_out == ($past(file_rdata_in) == ZERO_DATA))
    else $error("file move test did not update zero");

  AST_ONE_CYCLE: assert property (
    exec && (is_or_reg || is_or_lit || is_move || is_store)
      |=> state == ST_EXEC ##1 !discard_out)
    else $error("plain instruction took extra cycle");

  AST_NO_SKIP: assert property (
    exec && (is_dec || is_inc) && !alu_zero ##1 instr_valid_in |=> !discard_out)
    else $error("non-zero skip result discarded next word");

  // idle cycles must not use up a pending discard
  AST_FLUSH_HOLD: assert property (
    state == ST_FLUSH && !instr_valid_in |=> state == ST_FLUSH && !discard_out)
    else $error("idle cycle consumed the pending discard");

  AST_DISCARD_QUIET: assert property (
    discard_out |-> !file_we_out && !zero_we_out && !pc_load_out && !unknown_op_out &&
      acc_out == $past(acc_out))
    else $error("discarded word had an effect");

  AST_IDLE_CYCLE: assert property (
    exec && !(is_dec || is_inc || is_or_reg || is_move || is_store || is_or_lit || is_jump)
      |=> unknown_op_out == !$past(known) && !file_we_out && !zero_we_out && !pc_load_out &&
      acc_out == $past(acc_out) && state == ST_EXEC)
    else $error("idle or foreign word had an effect");

  AST_JUMP_CYCLES: assert property (
    exec && is_jump ##1 instr_valid_in |=> discard_out && !pc_load_out)
    else $error("jump did not spend a second cycle");

  COV_DEC_SKIP: cover property (exec && is_dec && file_rdata_in == ONE ##2 discard_out);
  COV_FLUSH_WAIT: cover property (state == ST_FLUSH && !instr_valid_in ##1 instr_valid_in);
  COV_JUMP: cover property (exec && is_jump ##1 pc_load_out);
  COV_MOVE_TEST: cover property (exec && is_move && dest_file ##1 zero_out);
  COV_INC_SKIP: cover property (exec && is_inc && file_rdata_in == 8'hFF);
endmodule
`default_nettype wire

// ---- verification/sbm_exec_bench.sv ----
// Purpose: self-checking bench for the skip/branch/move execution slice
// Assumes: file registers and status live here, read combinationally
// Notes: an integer model predicts every registered result one cycle on
`default_nettype none
module sbm_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sbm_pkg::*;
  localparam logic [11:0] BASES [8] = '{12'h2C0, 12'h3C0, 12'h100, 12'h200,
    12'h020, 12'hD00, 12'hA00, 12'h000};
  localparam logic [11:0] MASKS [8] = '{12'h03F, 12'h03F, 12'h03F, 12'h03F,
    12'h01F, 12'h0FF, 12'h1FF, 12'h000};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] instr_in = 12'h000;
  logic instr_valid_in = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic [7:0] file_rdata_in;
  logic [4:0] file_raddr_out, file_waddr_out;
  logic [7:0] file_wdata_out, acc_out;
  logic file_we_out, zero_we_out, zero_out, pc_load_out, discard_out, unknown_op_out;
  logic [10:0] pc_target_out;
  logic [7:0] fregs [32];
  int num_errors = 0;
  int num_checks = 0;
  int m_acc = 0;
  int m_flush = 0;

  always #2 clk_in = ~clk_in;
  assign file_rdata_in = fregs[file_raddr_out];

  sbm_exec u_dut (.clk_in(clk_in), .rst_in(rst_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .file_rdata_in(file_rdata_in), .status_in(status_in),
    .file_raddr_out(file_raddr_out), .file_we_out(file_we_out),
    .file_waddr_out(file_waddr_out), .file_wdata_out(file_wdata_out), .acc_out(acc_out),
    .zero_we_out(zero_we_out), .zero_out(zero_out), .pc_load_out(pc_load_out),
    .pc_target_out(pc_target_out), .discard_out(discard_out),
    .unknown_op_out(unknown_op_out));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input int exp, input logic [10:0] got);
    num_checks++;
    if (got !== 11'(exp)) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done, checks %0d mismatches %0d", name, num_checks, num_errors);
  endtask

  // sync reset: raised and dropped on falling edges
  task automatic do_reset(input int n);
    rst_in = 1'b1;
    instr_valid_in = 1'b0;
    repeat (n) @(negedge clk_in);
    rst_in = 1'b0;
    m_acc = 0;
    m_flush = 0;
    chk("acc reset", 0, 11'(acc_out));
    chk("zero reset", 0, 11'(zero_out));
    chk("target reset", 0, pc_target_out);
    chk("pulses reset", 0, 11'({file_we_out, zero_we_out, pc_load_out, discard_out,
      unknown_op_out}));
  endtask

  // offer one word, predict, then compare one cycle later
  task automatic step(input logic [11:0] ins, input logic vld, input logic [7:0] st);
    int f, r, we, ze, pl, pt, di, un;
    instr_in = ins;
    instr_valid_in = vld;
    status_in = st;
    f = fregs[ins[4:0]];
    r = -1;
    we = 0;
    ze = 0;
    pl = 0;
    pt = 0;
    di = 0;
    un = 0;
    if (vld && m_flush != 0) begin
      di = 1;
      m_flush = 0;
    end else if (vld) begin
      if (ins[11:6] == OP_DEC_SKIP) r = (f + 255) % 256;
      else if (ins[11:6] == OP_INC_SKIP) r = (f + 1) % 256;
      else if (ins[11:6] == OP_OR_REG) r = m_acc | f;
      else if (ins[11:6] == OP_MOVE_F) r = f;
      if (r >= 0) begin
        ze = int'(ins[11:6] == OP_OR_REG || ins[11:6] == OP_MOVE_F);
        if (ze == 0) m_flush = int'(r == 0);
        if (ins[5]) we = 1;
        else m_acc = r;
      end else if (ins[11:5] == OP_STORE_ACC) begin
        we = 1;
        r = m_acc;
      end else if (ins[11:8] == OP_OR_LIT) begin
        m_acc = m_acc | ins[7:0];
        r = m_acc;
        ze = 1;
      end else if (ins[11:9] == OP_JUMP) begin
        pl = 1;
        m_flush = 1;
        pt = {st[6:5], ins[8:0]};
      end else if (ins != OP_IDLE) un = 1;
    end
    #1;
    chk("file_raddr", ins[4:0], 11'(file_raddr_out));
    @(negedge clk_in);
    if (we != 0) fregs[ins[4:0]] = 8'(r);
    chk("file_we", we, 11'(file_we_out));
    if (we != 0) chk("file_waddr", ins[4:0], 11'(file_waddr_out));
    if (we != 0) chk("file_wdata", r, 11'(file_wdata_out));
    chk("acc", m_acc, 11'(acc_out));
    chk("zero_we", ze, 11'(zero_we_out));
    if (ze != 0) chk("zero", int'(r == 0), 11'(zero_out));
    chk("pc_load", pl, 11'(pc_load_out));
    if (pl != 0) chk("pc_target", pt, pc_target_out);
    chk("discard", di, 11'(discard_out));
    chk("unknown", un, 11'(unknown_op_out));
  endtask

  initial begin
    int k;
    void'($urandom(24));
    foreach (fregs[i]) fregs[i] = 8'($urandom);
    do_reset(6);
    test_done("reset");
    fregs[3] = 8'h01;
    step(12'h2E3, 1'b1, 8'h00);
    step(12'hDFF, 1'b1, 8'h00);
    fregs[4] = 8'hFF;
    step(12'h3C4, 1'b1, 8'h00);
    step(12'h000, 1'b0, 8'h00);
    step(12'hD5A, 1'b1, 8'h00);
    fregs[5] = 8'hFF;
    step(12'h3C5, 1'b1, 8'h00);
    step(12'hD01, 1'b1, 8'h00);
    step(12'h2C3, 1'b1, 8'h00);
    step(12'hD00, 1'b1, 8'h00);
    test_done("skips");
    for (int p = 0; p < 4; p++) begin
      k = (p == 3) ? 511 : p * 100;
      step(12'hA00 | 12'(k), 1'b1, 8'(p << 5) | 8'h9F);
      step(12'hDFF, 1'b1, 8'h00);
    end
    test_done("jumps");
    step(12'hF00, 1'b1, 8'h00);
    step(12'h200, 1'b1, 8'h00);
    step(12'hD00, 1'b1, 8'h00);
    step(12'hDA5, 1'b1, 8'h00);
    fregs[7] = 8'h00;
    step(12'h227, 1'b1, 8'h00);
    step(12'h207, 1'b1, 8'h00);
    step(12'hD3C, 1'b1, 8'h00);
    step(12'h03F, 1'b1, 8'h00);
    step(12'h13F, 1'b1, 8'h00);
    step(12'h11F, 1'b1, 8'h00);
    step(12'h7C0, 1'b1, 8'h00);
    test_done("or_move");
    for (int i = 0; i < 400; i++) begin
      k = $urandom_range(7);
      if (i == 200) do_reset(2);
      step(BASES[k] | (12'($urandom) & MASKS[k]), 1'($urandom_range(3) != 0),
        8'($urandom));
    end
    test_done("random");
    stop_test();
  end

  // about 450 cycles expected; five times that is a hang
  initial begin
    #10000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
